// >>> inc/dcks_pkg.sv
// package: command codes, states, pin struct, bank and burst constants for the cke/command state logic
package dcks_pkg;

  // decoded command set
  typedef enum logic [3:0] {
    DCKS_CMD_DESEL,
    DCKS_CMD_NOP,
    DCKS_CMD_ACT,
    DCKS_CMD_PRE,
    DCKS_CMD_RD,
    DCKS_CMD_WR,
    DCKS_CMD_REF,
    DCKS_CMD_MRS
  } dcks_cmd_t;

  // device-level state
  typedef enum logic [2:0] {
    DCKS_ST_IDLE,
    DCKS_ST_ACTIVE,
    DCKS_ST_READ,
    DCKS_ST_WRITE,
    DCKS_ST_PDN_PRE,
    DCKS_ST_PDN_ACT,
    DCKS_ST_SELF_REF
  } dcks_state_t;

  // command pins, cs/ras/cas/we active low as on the package balls; bank is not inverted
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [1:0] bank;
  } dcks_cmd_pins_t;

  localparam int  DCKS_BANKS          = 4;
  localparam int  DCKS_BANK_W         = 2;
  localparam int  DCKS_BURST_LEN      = 4;
  localparam int  DCKS_BURST_CNT_W    = 3;
  localparam int  DCKS_RST_STATE_IDLE = 0;
  localparam logic [DCKS_BANKS-1:0] DCKS_BANK_OPEN_RST = 4'h0;

endpackage : dcks_pkg

// >>> verilog/dcks_cmd_decode.sv
// command decoder: pin pattern to command code
`timescale 1ns/1ps

module dcks_cmd_decode
  import dcks_pkg::*;
(
  input  wire dcks_cmd_pins_t pins,
  output dcks_cmd_t           cmd
);

  // decode follows the cs/ras/cas/we pattern of the command table
  wire [2:0] rcw = {pins.ras_n, pins.cas_n, pins.we_n};

  assign cmd = pins.cs_n      ? DCKS_CMD_DESEL :
               (rcw == 3'h7) ? DCKS_CMD_NOP   :
               (rcw == 3'h3) ? DCKS_CMD_ACT   :
               (rcw == 3'h2) ? DCKS_CMD_PRE   :
               (rcw == 3'h5) ? DCKS_CMD_RD    :
               (rcw == 3'h4) ? DCKS_CMD_WR    :
               (rcw == 3'h1) ? DCKS_CMD_REF   :
               (rcw == 3'h0) ? DCKS_CMD_MRS   : DCKS_CMD_NOP;

endmodule // dcks_cmd_decode

// >>> verilog/dcks_ddr2_cke_state.sv
// ddr2 clock-enable and command state logic with write masking
//
// Overview of operation
// - action from cke now, cke before, command, state
// - refresh with cke falling and all banks closed enters self refresh
// - cke fall/rise with nop enters/exits power down
// - self refresh held while cke low, exit nop
// - odt ignored by state; odt off in self refresh
// - idle accepts act, pre, refresh, mrs only
// - active accepts read, write, pre, act to a closed bank only
// - bursts continue or same-direction interrupt only
// - high mask inhibits write of its beat
`timescale 1ns/1ps

module dcks_ddr2_cke_state
  import dcks_pkg::*;
#(
  parameter int BURST_LEN = DCKS_BURST_LEN,
  parameter int DATA_W    = 8
) (
  input  wire logic           clk_sys,
  input  wire logic           reset,
  input  wire logic           cke,
  input  wire dcks_cmd_pins_t cmd_pins,
  input  wire logic           odt,
  input  wire logic           wr_beat_valid,
  input  wire logic           wr_mask,
  input  wire logic [DATA_W-1:0] wr_data,
  output dcks_state_t         state,
  output logic [DCKS_BANKS-1:0] bank_open,
  output logic                cmd_illegal,
  output logic                odt_active,
  output logic                mem_write,
  output logic [DATA_W-1:0]   mem_wdata
);

  logic                          cke_prev;
  logic [DCKS_BURST_CNT_W-1:0]   burst_cnt;
  dcks_state_t                   next_state;
  logic [DCKS_BANKS-1:0]         next_bank_open;
  dcks_cmd_t                     cmd;

  dcks_cmd_decode u_dec (
    .pins (cmd_pins),
    .cmd  (cmd)
  );

  // edge classification of the two cke samples
  wire cke_hh   = cke_prev & cke;
  wire cke_fall = cke_prev & ~cke;
  wire cke_rise = ~cke_prev & cke;
  wire is_nop   = (cmd == DCKS_CMD_DESEL) || (cmd == DCKS_CMD_NOP);
  wire any_open = |bank_open;
  wire tgt_open = bank_open[cmd_pins.bank];
  wire burst_last = (burst_cnt == DCKS_BURST_CNT_W'(BURST_LEN / 2 - 1));
  wire in_burst = (state == DCKS_ST_READ) || (state == DCKS_ST_WRITE);
  // bl4 bursts cannot be interrupted
  wire bl_intr_ok = (BURST_LEN != 4);
  wire ref_or_mrs = (cmd == DCKS_CMD_REF) || (cmd == DCKS_CMD_MRS);

  // next state decision from cke pair, command and current state
  always_comb begin
    next_state     = state;
    next_bank_open = bank_open;
    cmd_illegal    = 1'b0;
    unique case (state)
      DCKS_ST_IDLE, DCKS_ST_ACTIVE: begin
        if (cke_fall) begin
          if (is_nop) begin
            next_state = any_open ? DCKS_ST_PDN_ACT : DCKS_ST_PDN_PRE;
          end else if (cmd == DCKS_CMD_REF && !any_open) begin
            next_state = DCKS_ST_SELF_REF;
          end else begin
            cmd_illegal = 1'b1;
          end
        end else if (cke_rise) begin
          cmd_illegal = 1'b1;
        end else if (cke_hh) begin
          case (cmd)
            DCKS_CMD_ACT: begin
              if (tgt_open) cmd_illegal = 1'b1;
              else next_bank_open[cmd_pins.bank] = 1'b1;
            end
            DCKS_CMD_PRE: begin
              next_bank_open[cmd_pins.bank] = 1'b0;
            end
            DCKS_CMD_RD, DCKS_CMD_WR: begin
              // read/write only to an open bank
              if (!tgt_open) cmd_illegal = 1'b1;
              else next_state = (cmd == DCKS_CMD_RD) ? DCKS_ST_READ : DCKS_ST_WRITE;
            end
            DCKS_CMD_REF, DCKS_CMD_MRS: begin
              if (any_open) cmd_illegal = 1'b1;
            end
            default: ;
          endcase
          if (next_state == state || next_state == DCKS_ST_ACTIVE
              || next_state == DCKS_ST_IDLE)
            if (!in_burst && (next_state == DCKS_ST_IDLE || next_state == DCKS_ST_ACTIVE))
              next_state = (|next_bank_open) ? DCKS_ST_ACTIVE : DCKS_ST_IDLE;
        end
      end
      DCKS_ST_READ, DCKS_ST_WRITE: begin
        if (!cke_hh) begin
          cmd_illegal = 1'b1;
        end else if (is_nop) begin
          if (burst_last) next_state = DCKS_ST_ACTIVE;
        end else if ((state == DCKS_ST_READ && cmd == DCKS_CMD_RD) ||
                     (state == DCKS_ST_WRITE && cmd == DCKS_CMD_WR)) begin
          if (!bl_intr_ok || !tgt_open) cmd_illegal = 1'b1;
        end else begin
          cmd_illegal = 1'b1;
        end
      end
      DCKS_ST_PDN_PRE, DCKS_ST_PDN_ACT: begin
        // pins other than cke are ignored while cke stays low
        if (cke_rise) begin
          if (is_nop) next_state = (state == DCKS_ST_PDN_ACT) ? DCKS_ST_ACTIVE
                                                                : DCKS_ST_IDLE;
          else cmd_illegal = 1'b1;
        end
      end
      DCKS_ST_SELF_REF: begin
        if (cke_rise) begin
          if (is_nop) next_state = DCKS_ST_IDLE;
          else cmd_illegal = 1'b1;
        end
      end
      default: next_state = DCKS_ST_IDLE;
    endcase
    if (ref_or_mrs && cke_hh && !in_burst && any_open) cmd_illegal = 1'b1;
  end

  // state registers; no reset pin on the part, reset here is local
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state     <= DCKS_ST_IDLE;
      bank_open <= DCKS_BANK_OPEN_RST;
      cke_prev  <= cke;  // tracks the pin so release shows no false edge
    end else begin
      state     <= next_state;
      bank_open <= next_bank_open;
      cke_prev  <= cke;
    end
  end

  // burst beat counter; restarts on every accepted read or write
  wire burst_start = (next_state == DCKS_ST_READ || next_state == DCKS_ST_WRITE)
                     && !cmd_illegal && (cmd == DCKS_CMD_RD || cmd == DCKS_CMD_WR);
  always_ff @(posedge clk_sys) begin
    if (reset) burst_cnt <= '0;
    else if (burst_start) burst_cnt <= '0;
    else if (in_burst) burst_cnt <= burst_cnt + 1'b1;
  end

  // odt only matters outside self refresh and never steers state
  assign odt_active = odt && (state != DCKS_ST_SELF_REF);

  // masked write path: high mask suppresses the beat
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      mem_write <= 1'b0;
      mem_wdata <= '0;
    end else begin
      mem_write <= wr_beat_valid && (state == DCKS_ST_WRITE) && !wr_mask;
      mem_wdata <= wr_data;
    end
  end

  // checks
  property p_sr_entry;
    @(posedge clk_sys) disable iff (reset)
      (state == DCKS_ST_IDLE && cke_fall && cmd == DCKS_CMD_REF && bank_open == '0)
      |=> state == DCKS_ST_SELF_REF;
  endproperty
  a_sr_entry: assert property (p_sr_entry) else $error("self refresh not entered");

  property p_pd_entry;
    @(posedge clk_sys) disable iff (reset)
      ((state == DCKS_ST_IDLE || state == DCKS_ST_ACTIVE) && cke_fall && is_nop)
      |=> (state == DCKS_ST_PDN_ACT) == $past(any_open) &&
          (state == DCKS_ST_PDN_ACT || state == DCKS_ST_PDN_PRE);
  endproperty
  a_pd_entry: assert property (p_pd_entry) else $error("wrong power down type");

  property p_pd_hold;
    @(posedge clk_sys) disable iff (reset)
      (state == DCKS_ST_PDN_PRE && !cke) |=> state == DCKS_ST_PDN_PRE;
  endproperty
  a_pd_hold: assert property (p_pd_hold) else $error("power down left with cke low");

  property p_sr_exit;
    @(posedge clk_sys) disable iff (reset)
      (state == DCKS_ST_SELF_REF && cke_rise && is_nop) |=> state == DCKS_ST_IDLE;
  endproperty
  a_sr_exit: assert property (p_sr_exit) else $error("self refresh exit failed");

  property p_sr_hold;
    @(posedge clk_sys) disable iff (reset)
      (state == DCKS_ST_SELF_REF && !cke) |=> state == DCKS_ST_SELF_REF;
  endproperty
  a_sr_hold: assert property (p_sr_hold) else $error("self refresh dropped");

  property p_odt_sr;
    @(posedge clk_sys) disable iff (reset)
      state == DCKS_ST_SELF_REF |-> !odt_active;
  endproperty
  a_odt_sr: assert property (p_odt_sr) else $error("odt active in self refresh");

  property p_idle_rd;
    @(posedge clk_sys) disable iff (reset)
      (state == DCKS_ST_IDLE && cke_hh && cmd == DCKS_CMD_RD) |-> cmd_illegal ##1
      state == DCKS_ST_IDLE;
  endproperty
  a_idle_rd: assert property (p_idle_rd) else $error("read in idle accepted");

  property p_act_rd;
    @(posedge clk_sys) disable iff (reset)
      (state == DCKS_ST_ACTIVE && cke_hh && cmd == DCKS_CMD_RD && tgt_open)
      |=> state == DCKS_ST_READ;
  endproperty
  a_act_rd: assert property (p_act_rd) else $error("read not started");

  property p_burst_dir;
    @(posedge clk_sys) disable iff (reset)
      (state == DCKS_ST_READ && cke_hh && cmd == DCKS_CMD_WR) |-> cmd_illegal;
  endproperty
  a_burst_dir: assert property (p_burst_dir) else $error("write in read burst");

  property p_mask;
    @(posedge clk_sys) disable iff (reset)
      (wr_beat_valid && wr_mask) |=> !mem_write;
  endproperty
  a_mask: assert property (p_mask) else $error("masked beat written");

  c_sr: cover property (@(posedge clk_sys) state == DCKS_ST_SELF_REF);
  c_pda: cover property (@(posedge clk_sys) state == DCKS_ST_PDN_ACT);
  c_wr: cover property (@(posedge clk_sys) mem_write);
  c_ill: cover property (@(posedge clk_sys) cmd_illegal);

endmodule // dcks_ddr2_cke_state

// >>> verification/dcks_ctrl_model.sv
// controller-side model: turns a requested command into pins and clock enable
`timescale 1ns/1ps

module dcks_ctrl_model
  import dcks_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       cke_req,
  input  wire dcks_cmd_t  op,
  input  wire logic [1:0] bank,
  input  wire logic [2:0] junk,
  output logic            cke,
  output dcks_cmd_pins_t  pins
);
  logic       cke_last = 1'b1;
  logic [1:0] held     = 2'h3;

  // count edges at the current level; a change is refused before three
  always @(posedge clk_sys) begin
    cke_last <= cke;
    held     <= (cke != cke_last) ? 2'h1 : ((held == 2'h3) ? held : held + 2'h1);
  end
  assign cke = (held < 2'h3) ? cke_last : cke_req;

  // only listed patterns are ever encoded; deselect carries junk on the rest
  always_comb begin
    pins.bank = bank;
    pins.cs_n = 1'b0;
    case (op)
      DCKS_CMD_ACT: {pins.ras_n, pins.cas_n, pins.we_n} = 3'h3;
      DCKS_CMD_PRE: {pins.ras_n, pins.cas_n, pins.we_n} = 3'h2;
      DCKS_CMD_RD:  {pins.ras_n, pins.cas_n, pins.we_n} = 3'h5;
      DCKS_CMD_WR:  {pins.ras_n, pins.cas_n, pins.we_n} = 3'h4;
      DCKS_CMD_REF: {pins.ras_n, pins.cas_n, pins.we_n} = 3'h1;
      DCKS_CMD_MRS: {pins.ras_n, pins.cas_n, pins.we_n} = 3'h0;
      DCKS_CMD_NOP: {pins.ras_n, pins.cas_n, pins.we_n} = 3'h7;
      default: begin
        pins.cs_n = 1'b1;
        {pins.ras_n, pins.cas_n, pins.we_n} = junk;
      end
    endcase
  end
endmodule  // dcks_ctrl_model

// >>> verification/tb.sv
// self-checking bench for the cke and command state logic
`timescale 1ns/1ps

module tb
  import dcks_pkg::*;
;
  typedef struct packed {
    dcks_state_t st; logic il; logic [3:0] bo; logic mw; logic [7:0] wd; logic oa;
  } dcks_exp_t;

  logic clk_sys = 1'b0, reset = 1'b1, cke_req = 1'b1, odt = 1'b0;
  logic wr_beat_valid = 1'b0, wr_mask = 1'b0, pend_mw = 1'b0, cke;
  logic [1:0] bank = 2'h0;
  logic [2:0] junk = 3'h0;
  logic [7:0] wr_data = 8'h00, pend_wd = 8'h00, mem_wdata;
  dcks_cmd_t op = DCKS_CMD_NOP;
  dcks_cmd_pins_t pins;
  dcks_state_t state;
  logic [3:0] bank_open;
  logic cmd_illegal, odt_active, mem_write;
  integer seed = 32'ha04af043, errors = 0, checked = 0;
  dcks_exp_t q[$];
  dcks_exp_t e;

  always #50 clk_sys = ~clk_sys;

  dcks_ctrl_model ctl (.clk_sys(clk_sys), .cke_req(cke_req), .op(op), .bank(bank),
    .junk(junk), .cke(cke), .pins(pins));
  dcks_ddr2_cke_state DUT (.clk_sys(clk_sys), .reset(reset), .cke(cke), .cmd_pins(pins),
    .odt(odt), .wr_beat_valid(wr_beat_valid), .wr_mask(wr_mask), .wr_data(wr_data),
    .state(state), .bank_open(bank_open), .cmd_illegal(cmd_illegal),
    .odt_active(odt_active), .mem_write(mem_write), .mem_wdata(mem_wdata));

  task automatic tally_and_finish();
    if (errors == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input bit ok, input string m);
    checked++;
    if (!ok) begin
      errors++;
      $display("Error %0t: %s", $time, m);
    end
  endtask

  // one command per edge; s is the state expected while it is presented
  task automatic step(input logic k, input dcks_cmd_t c, input dcks_state_t s,
                      input logic il, input logic [3:0] bo,
                      input logic bv = 1'b0, input logic m = 1'b0,
                      input logic [1:0] b = 2'h0);
    logic [7:0] d;
    logic o;
    @(posedge clk_sys);
    d = 8'($random(seed));
    o = 1'($random(seed));
    cke_req <= k; op <= c; odt <= o; wr_data <= d; bank <= b;
    wr_beat_valid <= bv; wr_mask <= m; junk <= 3'($random(seed));
    q.push_back('{s, il, bo, pend_mw, pend_wd, o && (s != DCKS_ST_SELF_REF)});
    pend_mw = bv && !m && (s == DCKS_ST_WRITE);
    pend_wd = d;
  endtask

  // outputs are settled by the falling edge
  always @(negedge clk_sys) if (q.size() > 0) begin
    e = q.pop_front();
    chk(state === e.st, "state");
    chk(cmd_illegal === e.il, "illegal flag");
    chk(bank_open === e.bo, "bank open");
    chk(mem_write === e.mw, "write strobe");
    if (e.mw) chk(mem_wdata === e.wd, "write data");
    chk(odt_active === e.oa, "termination");
  end

  initial begin
    repeat (3000) @(posedge clk_sys);
    errors++;
    tally_and_finish();
  end

  initial begin
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    step(1, DCKS_CMD_NOP, DCKS_ST_IDLE, 0, 4'h0);
    step(1, DCKS_CMD_RD, DCKS_ST_IDLE, 1, 4'h0);
    step(1, DCKS_CMD_ACT, DCKS_ST_IDLE, 0, 4'h0);
    step(1, DCKS_CMD_REF, DCKS_ST_ACTIVE, 1, 4'h1);
    step(1, DCKS_CMD_ACT, DCKS_ST_ACTIVE, 1, 4'h1);
    step(1, DCKS_CMD_WR, DCKS_ST_ACTIVE, 0, 4'h1);
    step(1, DCKS_CMD_NOP, DCKS_ST_WRITE, 0, 4'h1, 1, 0);
    step(1, DCKS_CMD_NOP, DCKS_ST_WRITE, 0, 4'h1, 1, 1);
    step(1, DCKS_CMD_RD, DCKS_ST_ACTIVE, 0, 4'h1);
    step(1, DCKS_CMD_WR, DCKS_ST_READ, 1, 4'h1);
    step(1, DCKS_CMD_DESEL, DCKS_ST_READ, 0, 4'h1);
    // cke held three edges after every change
    step(0, DCKS_CMD_NOP, DCKS_ST_ACTIVE, 0, 4'h1);
    step(0, DCKS_CMD_DESEL, DCKS_ST_PDN_ACT, 0, 4'h1);
    step(0, DCKS_CMD_DESEL, DCKS_ST_PDN_ACT, 0, 4'h1);
    step(1, DCKS_CMD_NOP, DCKS_ST_PDN_ACT, 0, 4'h1);
    step(1, DCKS_CMD_NOP, DCKS_ST_ACTIVE, 0, 4'h1);
    step(1, DCKS_CMD_PRE, DCKS_ST_ACTIVE, 0, 4'h1);
    step(0, DCKS_CMD_REF, DCKS_ST_IDLE, 0, 4'h0);
    step(0, DCKS_CMD_DESEL, DCKS_ST_SELF_REF, 0, 4'h0);
    step(0, DCKS_CMD_DESEL, DCKS_ST_SELF_REF, 0, 4'h0);
    step(1, DCKS_CMD_NOP, DCKS_ST_SELF_REF, 0, 4'h0);
    step(1, DCKS_CMD_NOP, DCKS_ST_IDLE, 0, 4'h0);
    step(1, DCKS_CMD_DESEL, DCKS_ST_IDLE, 0, 4'h0);
    step(0, DCKS_CMD_NOP, DCKS_ST_IDLE, 0, 4'h0);
    step(0, DCKS_CMD_DESEL, DCKS_ST_PDN_PRE, 0, 4'h0);
    step(0, DCKS_CMD_DESEL, DCKS_ST_PDN_PRE, 0, 4'h0);
    step(1, DCKS_CMD_DESEL, DCKS_ST_PDN_PRE, 0, 4'h0);
    step(1, DCKS_CMD_NOP, DCKS_ST_IDLE, 0, 4'h0);
    // no read until the self refresh exit wait has run out
    repeat (200) @(posedge clk_sys);
    step(1, DCKS_CMD_MRS, DCKS_ST_IDLE, 0, 4'h0);
    step(1, DCKS_CMD_ACT, DCKS_ST_IDLE, 0, 4'h0, 0, 0, 2'h2);
    step(1, DCKS_CMD_RD, DCKS_ST_ACTIVE, 1, 4'h4);
    step(1, DCKS_CMD_MRS, DCKS_ST_ACTIVE, 1, 4'h4);
    step(1, DCKS_CMD_WR, DCKS_ST_ACTIVE, 0, 4'h4, 1, 0, 2'h2);
    // bl4 write may not be interrupted by a new write
    step(1, DCKS_CMD_WR, DCKS_ST_WRITE, 1, 4'h4, 1, 0, 2'h2);
    step(1, DCKS_CMD_NOP, DCKS_ST_WRITE, 0, 4'h4);
    step(1, DCKS_CMD_PRE, DCKS_ST_ACTIVE, 0, 4'h4, 0, 0, 2'h2);
    step(1, DCKS_CMD_NOP, DCKS_ST_IDLE, 0, 4'h0);
    repeat (2) @(posedge clk_sys);
    tally_and_finish();
  end
endmodule  // tb
